/* hw/pfgc_top.sv */
// pfgc_top: pin function, overtemp gating, fan override and general pin register bank
`timescale 1ns/1ns
module pfgc_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [pfgc_pkg::NCH-1:0][7:0] temp_reading,
  input wire logic [pfgc_pkg::NFAN-1:0][7:0] fan_duty_req,
  output logic [pfgc_pkg::NFAN-1:0][7:0] fan_duty,
  output logic [3:0] bypass_divider,
  output logic signed_temp_format,
  output logic overtemp_active,
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic fan_speed_input_4,
  input wire logic general_io_1_in,
  output logic general_io_1_out,
  output logic general_io_1_oe,
  input wire logic general_io_2_in,
  output logic general_io_2_out,
  output logic general_io_2_oe,
  output logic irq
);
  import pfgc_pkg::*;

  typedef struct packed {
    logic [7:0] cfg4;
    logic [7:0] cfg5;
    logic lock;
    logic [NCH-1:0][7:0] limit;
    logic [NFAN-1:0][7:0] maxspd;
    logic [1:0] gval;
    logic [1:0] gpol;
    logic [1:0] gdir;
    logic [1:0] gin_q;
    logic [NEV-1:0] ist;
    logic [NEV-1:0] imask;
    logic [7:0] rdata;
    logic ot;
    logic [NFAN-1:0][7:0] fan;
    logic sp_out;
    logic sp_oe;
    logic tach;
    logic [1:0] gout;
    logic [1:0] goe;
    logic irq;
  } pfgc_state_t;

  pfgc_state_t s_r;
  pfgc_state_t s_nxt;
  logic [1:0] gin;
  logic [NCH-1:0] ch_exceed;
  logic [NCH-1:0] ch_off;
  logic exceed_any;
  logic [NEV-1:0] ev;
  pfgc_func_t func;

  assign gin = {general_io_2_in, general_io_1_in};
  assign func = pfgc_func_t'(s_r.cfg4[CFG4_FUNC_LO +: 2]);

  // limit compare per channel; disable codes depend on the format bit
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ch_off[i] = s_r.cfg5[CFG5_FMT_BIT] ? (s_r.limit[i] == LIM_OFF_SIGNED)
                                         : (s_r.limit[i] == LIM_OFF_BIASED);
      if (s_r.cfg5[CFG5_FMT_BIT]) begin
        ch_exceed[i] = $signed(temp_reading[i]) > $signed(s_r.limit[i]);
      end else begin
        ch_exceed[i] = temp_reading[i] > s_r.limit[i];
      end
      ch_exceed[i] = ch_exceed[i] && !ch_off[i] && s_r.cfg5[CFG5_CHEN_LO + i];
    end
    exceed_any = |ch_exceed;
  end

  always_comb begin
    s_nxt = s_r;
    ev = '0;
    // writes; lock is sticky until reset
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CFG1: begin
          if (reg_wdata[CFG1_LOCK_BIT]) begin
            s_nxt.lock = 1'b1;
          end
        end
        ADDR_CFG5: begin
          if (!s_r.lock) begin
            s_nxt.cfg5 = reg_wdata;
          end else begin
            ev[EV_LOCKED_WR] = 1'b1;
          end
        end
        ADDR_CFG4: begin
          if (!s_r.lock) begin
            s_nxt.cfg4 = reg_wdata;
          end else begin
            ev[EV_LOCKED_WR] = 1'b1;
          end
        end
        ADDR_GPIO: begin
          s_nxt.gval = {reg_wdata[GPIO_VAL_LO], reg_wdata[GPIO_VAL_LO + 1]};
          s_nxt.gpol = {reg_wdata[GPIO_POL_LO], reg_wdata[GPIO_POL_LO + 1]};
          s_nxt.gdir = {reg_wdata[GPIO_DIR_LO], reg_wdata[GPIO_DIR_LO + 1]};
        end
        ADDR_ISTAT: s_nxt.ist = s_r.ist & ~reg_wdata[NEV-1:0];
        ADDR_IMASK: s_nxt.imask = reg_wdata[NEV-1:0];
        default: begin
          // test registers and unmapped addresses drop the write
          for (int i = 0; i < NCH; i++) begin
            if (reg_addr == ADDR_LIMIT0 + 8'(i) && !s_r.lock) begin
              s_nxt.limit[i] = reg_wdata;
            end
          end
          for (int i = 0; i < NFAN; i++) begin
            if (reg_addr == ADDR_MAXSPD0 + 8'(i) && !s_r.lock) begin
              s_nxt.maxspd[i] = reg_wdata;
            end
          end
        end
      endcase
    end
    // read data stand one cycle after the strobe only
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CFG1: s_nxt.rdata = 8'(s_r.lock) << CFG1_LOCK_BIT;
        ADDR_CFG5: s_nxt.rdata = s_r.cfg5;
        ADDR_CFG4: s_nxt.rdata = s_r.cfg4;
        ADDR_TEST_A: s_nxt.rdata = TEST_RST;
        ADDR_TEST_B: s_nxt.rdata = TEST_RST;
        ADDR_GPIO: begin
          // input pins show the live level, outputs the stored value
          s_nxt.rdata[GPIO_VAL_LO] = s_r.gdir[1] ? gin[1] : s_r.gval[1];
          s_nxt.rdata[GPIO_VAL_LO + 1] = s_r.gdir[0] ? gin[0] : s_r.gval[0];
          s_nxt.rdata[GPIO_POL_LO] = s_r.gpol[1];
          s_nxt.rdata[GPIO_POL_LO + 1] = s_r.gpol[0];
          s_nxt.rdata[GPIO_DIR_LO] = s_r.gdir[1];
          s_nxt.rdata[GPIO_DIR_LO + 1] = s_r.gdir[0];
        end
        ADDR_ISTAT: s_nxt.rdata = 8'(s_r.ist);
        ADDR_IMASK: s_nxt.rdata = 8'(s_r.imask);
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (reg_addr == ADDR_LIMIT0 + 8'(i)) begin
              s_nxt.rdata = s_r.limit[i];
            end
          end
          for (int i = 0; i < NFAN; i++) begin
            if (reg_addr == ADDR_MAXSPD0 + 8'(i)) begin
              s_nxt.rdata = s_r.maxspd[i];
            end
          end
        end
      endcase
    end
    // overtemp output gate
    s_nxt.ot = exceed_any && !s_r.cfg4[CFG4_OT_DIS_BIT];
    // fan override follows the limit crossing itself, not the pin gate
    for (int i = 0; i < NFAN; i++) begin
      if (exceed_any) begin
        s_nxt.fan[i] = s_r.cfg4[CFG4_OT_RESP_BIT] ? s_r.maxspd[i] : FULL_DUTY;
      end else begin
        s_nxt.fan[i] = fan_duty_req[i];
      end
    end
    // shared pin is open drain, low when asserted
    s_nxt.sp_out = 1'b0;
    s_nxt.sp_oe = 1'b0;
    s_nxt.tach = 1'b1;
    case (func)
      PF_TACH: s_nxt.tach = shared_pin_in;
      PF_OVERTEMP: s_nxt.sp_oe = s_r.ot;
      PF_ALERT: s_nxt.sp_oe = s_r.irq;
      PF_RESERVED: s_nxt.sp_oe = 1'b0;
      default: s_nxt.sp_oe = 1'b0;
    endcase
    // general pins, push-pull while an output
    for (int i = 0; i < 2; i++) begin
      s_nxt.goe[i] = !s_r.gdir[i];
      s_nxt.gout[i] = s_r.gpol[i] ? s_r.gval[i] : !s_r.gval[i];
    end
    // events; a set in the cycle of a clear wins
    s_nxt.gin_q = gin;
    ev[EV_OT] = s_nxt.ot && !s_r.ot;
    ev[EV_GIO1] = s_r.gdir[0] && (gin[0] != s_r.gin_q[0]);
    ev[EV_GIO2] = s_r.gdir[1] && (gin[1] != s_r.gin_q[1]);
    s_nxt.ist = s_nxt.ist | ev;
    s_nxt.irq = |(s_r.ist & s_r.imask);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.cfg4 <= CFG4_RST;
      s_r.cfg5 <= CFG5_RST;
      s_r.gval <= GPIO_RST[GPIO_VAL_LO +: 2];
      s_r.gpol <= GPIO_RST[GPIO_POL_LO +: 2];
      s_r.gdir <= GPIO_RST[GPIO_DIR_LO +: 2];
      s_r.limit <= {NCH{LIMIT_RST}};
      s_r.maxspd <= {NFAN{MAXSPD_RST}};
      s_r.fan <= {NFAN{FULL_DUTY}};
      s_r.tach <= 1'b1;
      s_r.goe <= 2'b11;
      s_r.gout <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign fan_duty = s_r.fan;
  assign bypass_divider = s_r.cfg4[CFG4_BYPASS_LO +: 4];
  assign signed_temp_format = s_r.cfg5[CFG5_FMT_BIT];
  assign overtemp_active = s_r.ot;
  assign shared_pin_out = s_r.sp_out;
  assign shared_pin_oe = s_r.sp_oe;
  assign fan_speed_input_4 = s_r.tach;
  assign general_io_1_out = s_r.gout[0];
  assign general_io_1_oe = s_r.goe[0];
  assign general_io_2_out = s_r.gout[1];
  assign general_io_2_oe = s_r.goe[1];
  assign irq = s_r.irq;

  // checks
  sequence s_cfg4_write;
    reg_wr && reg_addr == ADDR_CFG4;
  endsequence

  sequence s_test_read;
    reg_rd && (reg_addr == ADDR_TEST_A || reg_addr == ADDR_TEST_B);
  endsequence

  a_pin_func_tach: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n && func == PF_TACH |=> !shared_pin_oe && fan_speed_input_4 == $past(shared_pin_in))
    else $error("shared pin driven in tach mode");

  a_pin_func_ot: assert property (@(posedge clock) disable iff (!arst_n)
    func == PF_OVERTEMP |=> shared_pin_oe == $past(overtemp_active) && !shared_pin_out)
    else $error("shared pin does not follow overtemp");

  a_ot_enable: assert property (@(posedge clock) disable iff (!arst_n)
    exceed_any && !s_r.cfg4[CFG4_OT_DIS_BIT] |=> overtemp_active)
    else $error("overtemp not raised");

  a_ot_disable: assert property (@(posedge clock) disable iff (!arst_n)
    s_r.cfg4[CFG4_OT_DIS_BIT] |=> !overtemp_active)
    else $error("overtemp raised while disabled");

  a_limit_off: assert property (@(posedge clock) disable iff (!arst_n)
    (&ch_off) |-> !exceed_any ##1 !overtemp_active)
    else $error("disabled limits still trip overtemp");

  a_fan_full: assert property (@(posedge clock) disable iff (!arst_n)
    exceed_any && !s_r.cfg4[CFG4_OT_RESP_BIT] |=> fan_duty == {NFAN{FULL_DUTY}})
    else $error("fans not at full duty");

  a_fan_max: assert property (@(posedge clock) disable iff (!arst_n)
    exceed_any && s_r.cfg4[CFG4_OT_RESP_BIT] |=> fan_duty == $past(s_r.maxspd))
    else $error("fans not at maximum speed");

  a_cfg_locked: assert property (@(posedge clock) disable iff (!arst_n)
    s_cfg4_write and s_r.lock |=> $stable(s_r.cfg4) ##1 $stable(s_r.lock))
    else $error("locked config register changed");

  a_test_zero: assert property (@(posedge clock) disable iff (!arst_n)
    s_test_read |=> reg_rdata == TEST_RST)
    else $error("test register not zero");

  a_gpio_in: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && reg_addr == ADDR_GPIO && s_r.gdir[0] |=> reg_rdata[GPIO_VAL_LO + 1] == $past(general_io_1_in))
    else $error("input pin level not returned");

  a_gpio_out: assert property (@(posedge clock) disable iff (!arst_n)
    !s_r.gdir[1] |=> general_io_2_oe && general_io_2_out == ($past(s_r.gval[1]) ~^ $past(s_r.gpol[1])))
    else $error("output pin level wrong");

  a_gpio_rsvd: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && reg_addr == ADDR_GPIO |=> reg_rdata[1:0] == 2'b00)
    else $error("reserved bits not zero");

  // shared pin roles beyond tach and overtemp
  a_pin_func_alert: assert property (@(posedge clock) disable iff (!arst_n)
    func == PF_ALERT |=> shared_pin_oe == $past(irq) && !shared_pin_out)
    else $error("shared pin does not follow alert");

  a_pin_func_rsvd: assert property (@(posedge clock) disable iff (!arst_n)
    func == PF_RESERVED |=> !shared_pin_oe && fan_speed_input_4)
    else $error("shared pin active in reserved mode");

  a_tach_idle: assert property (@(posedge clock) disable iff (!arst_n)
    func != PF_TACH |=> fan_speed_input_4)
    else $error("tach input passes outside tach mode");

  a_pin_func_write: assert property (@(posedge clock) disable iff (!arst_n)
    reg_wr && reg_addr == ADDR_CFG4 && !s_r.lock |=> s_r.cfg4[1:0] == $past(reg_wdata[1:0]))
    else $error("pin function field not written");

  a_bypass_write: assert property (@(posedge clock) disable iff (!arst_n)
    reg_wr && reg_addr == ADDR_CFG4 && !s_r.lock |=> bypass_divider == $past(reg_wdata[7:4]))
    else $error("bypass bits not taken");

  // limit disable codes, one per format
  a_off_signed: assert property (@(posedge clock) disable iff (!arst_n)
    s_r.cfg5[CFG5_FMT_BIT] && s_r.limit[0] == LIM_OFF_SIGNED |-> !ch_exceed[0])
    else $error("signed disable code still trips");

  a_off_biased: assert property (@(posedge clock) disable iff (!arst_n)
    !s_r.cfg5[CFG5_FMT_BIT] && s_r.limit[0] == LIM_OFF_BIASED |-> !ch_exceed[0])
    else $error("biased disable code still trips");

  a_fmt_write: assert property (@(posedge clock) disable iff (!arst_n)
    reg_wr && reg_addr == ADDR_CFG5 && !s_r.lock |=> signed_temp_format == $past(reg_wdata[CFG5_FMT_BIT]))
    else $error("format bit not taken");

  // arst_n in the antecedent keeps the release edge, where the flops still hold reset values, out
  a_fan_normal: assert property (@(posedge clock) disable iff (!arst_n)
    arst_n && !exceed_any |=> fan_duty == $past(fan_duty_req))
    else $error("fan duty overridden without overtemp");

  // lock stickiness and lock protection of CFG5, the first limit address and the first maximum speed address
  a_lock_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    s_r.lock |=> s_r.lock)
    else $error("lock bit cleared without reset");

  a_cfg5_locked: assert property (@(posedge clock) disable iff (!arst_n)
    reg_wr && reg_addr == ADDR_CFG5 && s_r.lock |=> $stable(s_r.cfg5))
    else $error("locked format register changed");

  a_limit_locked: assert property (@(posedge clock) disable iff (!arst_n)
    reg_wr && reg_addr == ADDR_LIMIT0 && s_r.lock |=> $stable(s_r.limit))
    else $error("locked limit changed");

  a_maxspd_locked: assert property (@(posedge clock) disable iff (!arst_n)
    reg_wr && reg_addr == ADDR_MAXSPD0 && s_r.lock |=> $stable(s_r.maxspd))
    else $error("locked maximum speed changed");

  a_locked_event: assert property (@(posedge clock) disable iff (!arst_n)
    s_cfg4_write and s_r.lock |=> s_r.ist[EV_LOCKED_WR])
    else $error("locked write not flagged");

  // general pins, remaining value, polarity and direction checks
  a_general_io_2_value_in: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && reg_addr == ADDR_GPIO && s_r.gdir[1] |=> reg_rdata[GPIO_VAL_LO] == $past(general_io_2_in))
    else $error("second input pin level not returned");

  a_general_io_1_value_out: assert property (@(posedge clock) disable iff (!arst_n)
    !s_r.gdir[0] |=> general_io_1_oe && general_io_1_out == ($past(s_r.gval[0]) ~^ $past(s_r.gpol[0])))
    else $error("first output pin level wrong");

  a_gpio_pol_read: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && reg_addr == ADDR_GPIO |=> reg_rdata[5:4] == $past({s_r.gpol[0], s_r.gpol[1]}))
    else $error("polarity bits read wrong");

  a_general_io_1_direction_in: assert property (@(posedge clock) disable iff (!arst_n)
    s_r.gdir[0] |=> !general_io_1_oe)
    else $error("first input pin still driven");

  a_general_io_2_direction_in: assert property (@(posedge clock) disable iff (!arst_n)
    s_r.gdir[1] |=> !general_io_2_oe)
    else $error("second input pin still driven");

  a_gpio_val_write: assert property (@(posedge clock) disable iff (!arst_n)
    reg_wr && reg_addr == ADDR_GPIO |=> s_r.gval == $past({reg_wdata[GPIO_VAL_LO], reg_wdata[GPIO_VAL_LO + 1]}))
    else $error("pin value bits not taken");

  // test registers hold zero whatever is written to them
  a_test_rd_b: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && reg_addr == ADDR_TEST_B |=> reg_rdata == 8'h00)
    else $error("second test register not zero");
endmodule

/* hw/pfgc_pkg.sv */
// pfgc_pkg: constants of the pin function and general pin configuration bank
package pfgc_pkg;
  localparam int NCH = 3;
  localparam int NFAN = 3;
  localparam logic [7:0] ADDR_MAXSPD0 = 8'h38;
  localparam logic [7:0] ADDR_CFG1 = 8'h40;
  localparam logic [7:0] ADDR_LIMIT0 = 8'h6a;
  localparam logic [7:0] ADDR_CFG5 = 8'h7c;
  localparam logic [7:0] ADDR_CFG4 = 8'h7d;
  localparam logic [7:0] ADDR_TEST_A = 8'h7e;
  localparam logic [7:0] ADDR_TEST_B = 8'h7f;
  localparam logic [7:0] ADDR_GPIO = 8'h80;
  localparam logic [7:0] ADDR_ISTAT = 8'h90;
  localparam logic [7:0] ADDR_IMASK = 8'h91;
  localparam int CFG1_LOCK_BIT = 1;
  localparam int CFG4_FUNC_LO = 0;
  localparam int CFG4_OT_DIS_BIT = 2;
  localparam int CFG4_OT_RESP_BIT = 3;
  localparam int CFG4_BYPASS_LO = 4;
  localparam int CFG5_FMT_BIT = 0;
  localparam int CFG5_CHEN_LO = 5;
  localparam int GPIO_VAL_LO = 2;
  localparam int GPIO_POL_LO = 4;
  localparam int GPIO_DIR_LO = 6;
  localparam logic [7:0] CFG4_RST = 8'h00;
  localparam logic [7:0] CFG5_RST = 8'h01;
  localparam logic [7:0] GPIO_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [7:0] LIMIT_RST = 8'hff;
  localparam logic [7:0] MAXSPD_RST = 8'hff;
  localparam logic [7:0] FULL_DUTY = 8'hff;
  localparam logic [7:0] LIM_OFF_BIASED = 8'h00;
  localparam logic [7:0] LIM_OFF_SIGNED = 8'h80;
  localparam int NEV = 4;
  localparam int EV_OT = 0;
  localparam int EV_GIO1 = 1;
  localparam int EV_GIO2 = 2;
  localparam int EV_LOCKED_WR = 3;
  typedef enum logic [1:0] {
    PF_TACH = 2'b00,
    PF_OVERTEMP = 2'b01,
    PF_ALERT = 2'b10,
    PF_RESERVED = 2'b11
  } pfgc_func_t;
endpackage

/* tb/pfgc_top_tb.sv */
// pfgc_top_tb: self-checking bench for the pin function and general pin register bank
`timescale 1ns/1ns
module pfgc_top_tb;
  import pfgc_pkg::*;
  logic clock = 0;
  logic arst_n = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rv;
  logic reg_wr = 0, reg_rd = 0;
  logic [NCH-1:0][7:0] temp_reading = '0;
  logic [NFAN-1:0][7:0] fan_duty_req = '0, fan_duty;
  logic [3:0] bypass_divider;
  logic signed_temp_format, overtemp_active, shared_pin_in = 0, shared_pin_out, shared_pin_oe;
  logic fan_speed_input_4, general_io_1_in = 0, general_io_1_out, general_io_1_oe;
  logic general_io_2_in = 0, general_io_2_out, general_io_2_oe, irq;
  int mismatches = 0;
  int cmp_count = 0;

  pfgc_top DUT (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .temp_reading,
    .fan_duty_req, .fan_duty, .bypass_divider, .signed_temp_format, .overtemp_active, .shared_pin_in,
    .shared_pin_out, .shared_pin_oe, .fan_speed_input_4, .general_io_1_in, .general_io_1_out,
    .general_io_1_oe, .general_io_2_in, .general_io_2_out, .general_io_2_oe, .irq);

  initial begin
    forever #20 clock = ~clock;
  end

  task automatic finish_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clock);
    reg_wr <= 0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clock);
    reg_rd <= 0;
    #1 rv = reg_rdata;
    chk(rv, e);
  endtask

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clock);
    arst_n <= 0;
    repeat (4) @(posedge clock);
    arst_n <= 1;
  endtask

  task automatic t_reset;
    rchk(ADDR_CFG4, 8'h00);
    rchk(ADDR_GPIO, 8'h00);
    chk({general_io_1_oe, general_io_1_out, general_io_2_oe, general_io_2_out}, 8'h0f);
    @(posedge clock);
    shared_pin_in <= 0;
    settle;
    chk({shared_pin_oe, fan_speed_input_4}, 8'h00);
    @(posedge clock);
    shared_pin_in <= 1;
    settle;
    chk({shared_pin_oe, fan_speed_input_4}, 8'h01);
  endtask

  task automatic t_test_regs;
    wr(ADDR_TEST_A, 8'ha5);
    wr(ADDR_TEST_B, 8'h5a);
    rchk(ADDR_TEST_A, 8'h00);
    rchk(ADDR_TEST_B, 8'h00);
    rchk(8'h55, 8'h00);
  endtask

  task automatic t_bypass;
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CFG4, 8'h10 << i);
      settle;
      chk({4'h0, bypass_divider}, 8'h01 << i);
      rchk(ADDR_CFG4, 8'h10 << i);
    end
    // reserved code parks the shared pin: released and no tach pass-through
    wr(ADDR_CFG4, 8'h03);
    shared_pin_in <= 0;
    settle;
    chk({shared_pin_oe, fan_speed_input_4}, 8'h01);
  endtask

  task automatic t_overtemp;
    // only channel 0 enabled: reset limits of 0xff read as -1 in signed form
    wr(ADDR_CFG5, 8'h21);
    wr(ADDR_LIMIT0, 8'h20);
    wr(ADDR_IMASK, 8'h00);
    wr(ADDR_CFG4, 8'h01);
    fan_duty_req <= {3{8'h40}};
    settle;
    chk({overtemp_active, shared_pin_oe}, 8'h00);
    chk(fan_duty[0], 8'h40);
    @(posedge clock);
    temp_reading[0] <= 8'h30;
    settle;
    chk({overtemp_active, shared_pin_oe, irq}, 8'h06);
    for (int k = 0; k < NFAN; k++)
      chk(fan_duty[k], FULL_DUTY);
    rchk(ADDR_ISTAT, 8'h01);
    wr(ADDR_IMASK, 8'h01);
    wr(ADDR_CFG4, 8'h02);
    settle;
    chk({irq, shared_pin_oe, shared_pin_out}, 8'h06);
    wr(ADDR_ISTAT, 8'h01);
    settle;
    chk({irq, shared_pin_oe}, 8'h00);
    wr(ADDR_CFG4, 8'h04);
    settle;
    chk({7'h0, overtemp_active}, 8'h00);
    wr(ADDR_MAXSPD0, 8'h80);
    wr(ADDR_MAXSPD0 + 8'h01, 8'h90);
    wr(ADDR_CFG4, 8'h08);
    settle;
    chk(fan_duty[0], 8'h80);
    chk(fan_duty[1], 8'h90);
    chk(fan_duty[2], MAXSPD_RST);
    // 0x90 sits above the limit in either format, so only the disable code can hold it off
    @(posedge clock);
    temp_reading[0] <= 8'h90;
    wr(ADDR_CFG4, 8'h00);
    wr(ADDR_LIMIT0, LIM_OFF_SIGNED);
    settle;
    chk({signed_temp_format, overtemp_active}, 8'h02);
    wr(ADDR_CFG5, 8'he0);
    settle;
    chk({signed_temp_format, overtemp_active}, 8'h01);
    wr(ADDR_LIMIT0, LIM_OFF_BIASED);
    settle;
    chk({7'h0, overtemp_active}, 8'h00);
    @(posedge clock);
    temp_reading[0] <= 8'h00;
    wr(ADDR_ISTAT, 8'hff);
  endtask

  task automatic t_gpio;
    logic [3:0] b;
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      wr(ADDR_GPIO, {2'b00, b, 2'b11});
      settle;
      chk({general_io_1_oe, general_io_1_out}, {6'h0, 1'b1, b[1] ~^ b[3]});
      chk({general_io_2_oe, general_io_2_out}, {6'h0, 1'b1, b[0] ~^ b[2]});
    end
    rchk(ADDR_GPIO, 8'h3c);
    @(posedge clock);
    general_io_1_in <= 1;
    wr(ADDR_GPIO, 8'hc0);
    settle;
    chk({general_io_1_oe, general_io_2_oe}, 8'h00);
    rchk(ADDR_GPIO, 8'hc8);
    @(posedge clock);
    general_io_1_in <= 0;
    general_io_2_in <= 1;
    settle;
    rchk(ADDR_GPIO, 8'hc4);
  endtask

  task automatic t_lock;
    wr(ADDR_CFG4, 8'hf0);
    wr(ADDR_CFG1, 8'h02);
    wr(ADDR_CFG4, 8'h0f);
    settle;
    rchk(ADDR_CFG4, 8'hf0);
    chk({4'h0, bypass_divider}, 8'h0f);
    rchk(ADDR_ISTAT, 8'h0e);
    do_reset;
    rchk(ADDR_CFG4, 8'h00);
    wr(ADDR_CFG4, 8'h10);
    rchk(ADDR_CFG4, 8'h10);
  endtask

  initial begin
    #100000;
    mismatches++;
    finish_test;
  end

  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1;
    t_reset;
    t_test_regs;
    t_bypass;
    t_overtemp;
    t_gpio;
    t_lock;
    finish_test;
  end
endmodule
